/* File: rtl/ttc_pkg.sv */
// Shared offsets, field layouts, reset values and timing for the touch control registers
package ttc_pkg;

  // Register offsets on the serial port
  localparam logic [7:0] OFS_MODE      = 8'h09;
  localparam logic [7:0] OFS_GPO       = 8'h0a;
  localparam logic [7:0] OFS_PIN_SEL   = 8'h0b;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h0c;
  localparam logic [7:0] OFS_GW_CFG    = 8'h0d;
  localparam logic [7:0] OFS_GW_BASE   = 8'h0e;
  localparam logic [7:0] OFS_CHIP_RST  = 8'hb1;

  // Field positions
  localparam int COMP_BIT      = 2;
  localparam int GW_PORT_LSB   = 4;
  localparam int GW_DIR_BIT    = 3;
  localparam int FLAG_MODE     = 0;
  localparam int FLAG_COMP     = 1;
  localparam int FLAG_PMEM_WR  = 5;

  // Field codes and reset values
  localparam logic [1:0] MODE_ACTIVE   = 2'h0;
  localparam logic [1:0] MODE_DOZE     = 2'h1;
  localparam logic [1:0] MODE_SLEEP    = 2'h2;
  localparam logic [1:0] MODE_RSVD     = 2'h3;
  localparam logic [1:0] PORT_NORMAL   = 2'h0;
  localparam logic [1:0] PORT_PMEM     = 2'h1;
  localparam logic [7:0] BASE_MASK     = 8'h78;
  localparam logic [7:0] BASE_RESET    = 8'h00;
  localparam logic [7:0] RST_KEY_FIRST = 8'hde;
  localparam logic [7:0] RST_KEY_LAST  = 8'h00;
  localparam logic [2:0] WINDOW_LAST   = 3'h7;

  // Timing: internal work lengths in microseconds, clock in MHz
  localparam int CLK_MHZ        = 100;
  localparam int COMP_TIME_US   = 1000;
  localparam int MODE_ENTRY_US  = 1000;
  localparam int COMP_CYCLES    = COMP_TIME_US * CLK_MHZ;
  localparam int MODE_CYCLES    = MODE_ENTRY_US * CLK_MHZ;
  localparam int TIMER_W        = 24;

  // Serial slave sequencer states
  typedef enum logic [2:0] {
    SER_IDLE,
    SER_ADDR,
    SER_ADDR_ACK,
    SER_RX,
    SER_RX_ACK,
    SER_TX,
    SER_TX_ACK
  } ttc_ser_state_t;

endpackage

/* File: rtl/ttc_param_mem.sv */
// Shadow parameter memory with one write port and a registered read port
`timescale 1ns/1ns
module ttc_param_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clock,     // System clock
  input  wire logic             writeEn,   // Write strobe
  input  wire logic [AW-1:0]    writeAddr, // Write address
  input  wire logic [WIDTH-1:0] writeData, // Write data
  input  wire logic [AW-1:0]    readAddr,  // Read address
  output logic      [WIDTH-1:0] readData   // Registered read data
);

  logic [WIDTH-1:0] store [DEPTH];

  // Write on strobe, read always, data out one cycle later
  always_ff @(posedge clock) begin
    if (writeEn) begin
      store[writeAddr] <= writeData;
    end
    readData <= store[readAddr];
  end

endmodule

/* File: rtl/ttc_control_regs.sv */
// Control register bank of the touch controller behind its serial slave port
`timescale 1ns/1ns
module ttc_control_regs
  import ttc_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR  = 7'h2b,       // Arbitrary default address
  parameter int         COMP_CYCLES = ttc_pkg::COMP_CYCLES,
  parameter int         MODE_CYCLES = ttc_pkg::MODE_CYCLES
) (
  input  wire logic            clock,          // 100 MHz system clock
  input  wire logic            rst_n,          // Asynchronous reset, active low
  input  wire logic            sclIn,          // Serial clock level
  input  wire logic            sdaIn,          // Serial data level
  output logic                 sdaOut,         // Serial data drive value
  output logic                 sdaOe,          // Serial data drive enable
  input  wire logic [7:0]      pinIsGpo,       // Pins configured as general outputs
  input  wire logic [7:0]      pinIsPwm,       // Pins configured as pwm outputs
  input  wire logic            autoLightOn,    // Automatic lighting enabled
  input  wire logic [7:0]      powerupState,   // Output power-up parameter
  input  wire logic [7:0]      onLevel,        // On intensity level
  input  wire logic [7:0]      offLevel,       // Off intensity level
  input  wire logic            autoCompReq,    // Automatic compensation request
  output logic [7:0][7:0]      pinLevel,       // Intensity driven per pin
  output logic [1:0]           opMode,         // Current operating mode
  output logic                 compRunning,    // Compensation in progress
  output logic                 pmemMode,       // Port in parameter memory mode
  output logic [7:0]           irqFlags,       // Interrupt source flags
  output logic                 interruptOutN,  // Interrupt output, active low
  output logic                 chipResetPulse  // One-cycle whole chip reset
);

  import ttc_pkg::*;

  typedef struct packed {
    logic                   sclQ;
    logic                   sdaQ;
    ttc_ser_state_t         ser;
    logic [3:0]             bitCnt;
    logic [7:0]             shift;
    logic                   isRead;
    logic                   firstByte;
    logic [7:0]             regPtr;
    logic [7:0]             txByte;
    logic                   sdaOe;
    logic                   initDone;
    logic [1:0]             opMode;
    logic [1:0]             modePend;
    logic                   modePendValid;
    logic [TIMER_W-1:0]     modeTimer;
    logic                   compBusy;
    logic [TIMER_W-1:0]     compTimer;
    logic [7:0]             general_output_pin;
    logic [2:0]             pinSel;
    logic [7:0][7:0]        level;
    logic [1:0]             gwPort;
    logic                   gwDir;
    logic [7:0]             gwBase;
    logic                   keySeen;
    logic [7:0]             flags;
    logic                   irqN;
    logic                   chipReset;
    logic [7:0][7:0]        pinLevel;
  } ttc_state_t;

  // Constant reset image of the whole state
  function automatic ttc_state_t resetImage();
    ttc_state_t r;
    r = '0;
    r.sclQ = 1'b1;
    r.sdaQ = 1'b1;
    r.ser = SER_IDLE;
    r.opMode = MODE_ACTIVE;
    r.gwPort = PORT_NORMAL;
    r.gwBase = BASE_RESET;
    r.irqN = 1'b1;
    return r;
  endfunction

  localparam ttc_state_t ST_RESET = resetImage();
  localparam logic [TIMER_W-1:0] COMP_LOAD = TIMER_W'(COMP_CYCLES - 1);
  localparam logic [TIMER_W-1:0] MODE_LOAD = TIMER_W'(MODE_CYCLES - 1);

  ttc_state_t s;
  ttc_state_t n;
  logic       sclRise;
  logic       sclFall;
  logic       busStart;
  logic       busStop;
  logic       wr;
  logic [7:0] wAddr;
  logic [7:0] wData;
  logic       inPmem;
  logic       memWr;
  logic [7:0] memData;
  logic [7:0] rdByte;

  // Register read decode, shared by first and following bytes of a read
  function automatic logic [7:0] readReg(input ttc_state_t st, input logic [7:0] mem);
    logic [7:0] v;
    v = 8'h00;
    if (st.gwPort == PORT_PMEM && st.regPtr < 8'h08) begin
      v = mem;
    end else begin
      case (st.regPtr)
        OFS_MODE:      v = {5'h00, st.compBusy, st.opMode};
        OFS_GPO:       v = st.general_output_pin;
        OFS_PIN_SEL:   v = {5'h00, st.pinSel};
        OFS_PIN_LEVEL: v = st.level[st.pinSel];
        OFS_GW_CFG:    v = {2'h0, st.gwPort, st.gwDir, 3'h0};
        OFS_GW_BASE:   v = st.gwBase;
        default:       v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // Bus conditions seen between the previous and current samples
  assign sclRise  = sclIn & ~s.sclQ;
  assign sclFall  = ~sclIn & s.sclQ;
  assign busStart = sclIn & s.sclQ & s.sdaQ & ~sdaIn;
  assign busStop  = sclIn & s.sclQ & ~s.sdaQ & sdaIn;
  assign inPmem   = (s.gwPort == PORT_PMEM);
  assign wr       = (s.ser == SER_RX) & sclFall & (s.bitCnt == 4'h8) & ~s.firstByte
                    & ~busStart & ~busStop;
  assign wAddr    = s.regPtr;
  assign wData    = s.shift;
  assign memWr    = wr & inPmem & (wAddr < 8'h08) & ~s.gwDir;
  assign rdByte   = readReg(s, memData);

  // Window bytes sit at the base plus the low pointer bits
  ttc_param_mem #(
    .WIDTH (8),
    .DEPTH (128)
  ) u_pmem (
    .clock     (clock),
    .writeEn   (memWr),
    .writeAddr ({s.gwBase[6:3], s.regPtr[2:0]}),
    .writeData (wData),
    .readAddr  ({s.gwBase[6:3], s.regPtr[2:0]}),
    .readData  (memData)
  );

  // Next state of the serial sequencer and register bank
  always_comb begin
    n = s;
    n.sclQ = sclIn;
    n.sdaQ = sdaIn;
    n.chipReset = 1'b0;
    if (busStop) begin
      n.ser = SER_IDLE;
      n.sdaOe = 1'b0;
    end else if (busStart) begin
      n.ser = SER_ADDR;
      n.bitCnt = 4'h0;
      n.sdaOe = 1'b0;
    end else begin
      case (s.ser)
        SER_ADDR: begin
          if (sclRise) begin
            n.shift = {s.shift[6:0], sdaIn};
            n.bitCnt = s.bitCnt + 4'h1;
          end
          if (sclFall && s.bitCnt == 4'h8) begin
            if (s.shift[7:1] == SLAVE_ADDR) begin
              n.sdaOe = 1'b1;
              n.isRead = s.shift[0];
              n.firstByte = 1'b1;
              n.ser = SER_ADDR_ACK;
              if (s.shift[0]) begin
                n.flags = 8'h00; // Any read clears the flags
              end
            end else begin
              n.ser = SER_IDLE;
            end
          end
        end
        SER_ADDR_ACK, SER_TX_ACK: begin
          if (sclRise && s.ser == SER_TX_ACK && sdaIn) begin
            n.ser = SER_IDLE; // Host ended the read
          end else if (sclFall) begin
            n.bitCnt = 4'h0;
            if (s.isRead) begin
              n.txByte = rdByte;
              n.sdaOe = ~rdByte[7];
              n.regPtr = s.regPtr + 8'h01;
              n.ser = SER_TX;
            end else begin
              n.sdaOe = 1'b0;
              n.ser = SER_RX;
            end
          end
        end
        SER_RX: begin
          if (sclRise) begin
            n.shift = {s.shift[6:0], sdaIn};
            n.bitCnt = s.bitCnt + 4'h1;
          end
          if (sclFall && s.bitCnt == 4'h8) begin
            n.sdaOe = 1'b1;
            n.ser = SER_RX_ACK;
            n.firstByte = 1'b0;
            n.regPtr = s.firstByte ? s.shift : s.regPtr + 8'h01;
          end
        end
        SER_RX_ACK: begin
          if (sclFall) begin
            n.sdaOe = 1'b0;
            n.bitCnt = 4'h0;
            n.ser = SER_RX;
          end
        end
        SER_TX: begin
          if (sclRise) begin
            n.bitCnt = s.bitCnt + 4'h1;
          end
          if (sclFall) begin
            if (s.bitCnt == 4'h8) begin
              n.sdaOe = 1'b0;
              n.ser = SER_TX_ACK;
            end else begin
              n.sdaOe = ~s.txByte[3'h7 - s.bitCnt[2:0]];
            end
          end
        end
        default: begin
          n.ser = SER_IDLE;
          n.sdaOe = 1'b0;
        end
      endcase
    end

    // Register writes
    if (wr && inPmem && wAddr < 8'h08) begin
      if (wAddr[2:0] == WINDOW_LAST && !s.gwDir) begin
        n.flags[FLAG_PMEM_WR] = 1'b1;
      end
    end else if (wr) begin
      case (wAddr)
        OFS_MODE: begin
          if (wData[COMP_BIT] && !s.compBusy) begin
            n.compBusy = 1'b1;
            n.compTimer = COMP_LOAD;
          end
          if (wData[1:0] == MODE_SLEEP) begin
            n.opMode = MODE_SLEEP;
            n.modePendValid = 1'b0;
          end else if (wData[1:0] != MODE_RSVD) begin
            n.modePend = wData[1:0];
            n.modePendValid = 1'b1;
            n.modeTimer = MODE_LOAD;
          end
        end
        OFS_GPO:       n.general_output_pin = (wData & pinIsGpo) | (s.general_output_pin & ~pinIsGpo);
        OFS_PIN_SEL:   n.pinSel = wData[2:0];
        OFS_PIN_LEVEL: n.level[s.pinSel] = wData;
        OFS_GW_CFG: begin
          n.gwPort = wData[GW_PORT_LSB +: 2];
          n.gwDir = wData[GW_DIR_BIT];
        end
        OFS_GW_BASE:   n.gwBase = wData & BASE_MASK;
        OFS_CHIP_RST: begin
          n.keySeen = (wData == RST_KEY_FIRST);
          n.chipReset = s.keySeen && (wData == RST_KEY_LAST);
        end
        default: ;
      endcase
    end

    // Automatic compensation start and run timer
    if (autoCompReq && !s.compBusy) begin
      n.compBusy = 1'b1;
      n.compTimer = COMP_LOAD;
    end
    if (s.compBusy) begin
      if (s.compTimer == '0) begin
        n.compBusy = 1'b0;
        n.flags[FLAG_COMP] = 1'b1;
      end else begin
        n.compTimer = s.compTimer - 1'b1;
      end
    end

    // Requested active or doze mode takes effect after the entry time
    if (s.modePendValid) begin
      if (s.modeTimer == '0) begin
        n.opMode = s.modePend;
        n.modePendValid = 1'b0;
        n.flags[FLAG_MODE] = 1'b1;
      end else begin
        n.modeTimer = s.modeTimer - 1'b1;
      end
    end

    // Power-up load of output control and intensities
    if (!s.initDone) begin
      n.initDone = 1'b1;
      n.general_output_pin = powerupState;
      for (int i = 0; i < 8; i++) begin
        n.level[i] = powerupState[i] ? onLevel : offLevel;
      end
    end

    // Per-pin drive level
    for (int i = 0; i < 8; i++) begin
      if (pinIsPwm[i]) begin
        n.pinLevel[i] = n.level[i];
      end else if (pinIsGpo[i] && !autoLightOn) begin
        n.pinLevel[i] = n.general_output_pin[i] ? onLevel : offLevel;
      end else begin
        n.pinLevel[i] = 8'h00;
      end
    end

    n.irqN = ~|n.flags;
    if (s.chipReset) begin
      n = ST_RESET;
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= ST_RESET;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign sdaOut         = 1'b0 & s.sdaOe;
  assign sdaOe          = s.sdaOe;
  assign pinLevel       = s.pinLevel;
  assign opMode         = s.opMode;
  assign compRunning    = s.compBusy;
  assign pmemMode       = (s.gwPort == PORT_PMEM) & s.sdaQ | (s.gwPort == PORT_PMEM) & ~s.sdaQ;
  assign irqFlags       = s.flags;
  assign interruptOutN  = s.irqN;
  assign chipResetPulse = s.chipReset;

  // Checks next to the logic
  a_comp_start: assert property (@(posedge clock) disable iff (!rst_n)
    wr && wAddr == OFS_MODE && wData[COMP_BIT] && !s.compBusy && !s.chipReset
    |=> s.compBusy) else $error("compensation did not start");
  a_comp_done: assert property (@(posedge clock) disable iff (!rst_n)
    s.compBusy && s.compTimer == '0 && !s.chipReset |=> !s.compBusy && s.flags[FLAG_COMP])
    else $error("compensation end did not set flag");
  a_mode_entry: assert property (@(posedge clock) disable iff (!rst_n)
    s.modePendValid && s.modeTimer == '0 && !wr && !s.chipReset
    |=> s.opMode == $past(s.modePend) && s.flags[FLAG_MODE])
    else $error("mode entry wrong");
  a_mode_keep: assert property (@(posedge clock) disable iff (!rst_n)
    wr && wAddr == OFS_MODE && wData[1:0] == MODE_RSVD && !s.modePendValid && !s.chipReset
    |=> $stable(s.opMode) && !s.modePendValid) else $error("reserved mode changed mode");
  a_gpo_mask: assert property (@(posedge clock) disable iff (!rst_n)
    wr && wAddr == OFS_GPO && s.initDone && !s.chipReset
    |=> ((s.general_output_pin ^ $past(s.general_output_pin)) & ~$past(pinIsGpo)) == 8'h00)
    else $error("non-output bit changed");
  a_level_write: assert property (@(posedge clock) disable iff (!rst_n)
    wr && wAddr == OFS_PIN_LEVEL && s.initDone && !s.chipReset
    |=> s.level[$past(s.pinSel)] == $past(wData)) else $error("intensity not stored");
  a_pmem_flag: assert property (@(posedge clock) disable iff (!rst_n)
    memWr && wAddr[2:0] == WINDOW_LAST && !s.chipReset
    |=> s.flags[FLAG_PMEM_WR] && !interruptOutN) else $error("window write no interrupt");
  a_irq_pin: assert property (@(posedge clock) disable iff (!rst_n)
    interruptOutN == ~|irqFlags) else $error("interrupt pin disagrees with flags");
  a_base_align: assert property (@(posedge clock) disable iff (!rst_n)
    s.gwBase[2:0] == 3'h0 && s.gwBase <= BASE_MASK) else $error("window base misaligned");
  a_soft_reset: assert property (@(posedge clock) disable iff (!rst_n)
    wr && wAddr == OFS_CHIP_RST && wData == RST_KEY_LAST && s.keySeen && !s.chipReset
    |=> chipResetPulse ##1 (s.opMode == MODE_ACTIVE && !s.initDone))
    else $error("reset key pair ignored");
  a_powerup: assert property (@(posedge clock) disable iff (!rst_n)
    !s.initDone && !s.chipReset |=> s.general_output_pin == $past(powerupState))
    else $error("output control not loaded");

endmodule

/* File: verif/ttc_i2c_host.sv */
// Serial bus host model driving the clock and data lines of the register port
`timescale 1ns/1ns
module ttc_i2c_host #(
  parameter logic [6:0] DEV_ADDR = 7'h2b  // Must match the slave address
) (
  input  wire logic clock,    // System clock
  input  wire logic sdaLine,  // Resolved data line level
  output logic      sclLine,  // Serial clock level
  output logic      sdaLow    // High while the host pulls data low
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    sclLine = 1'b1;
    sdaLow  = 1'b0;
  end

  // One bus phase of four clocks, changes land just after an edge
  task automatic phase();
    repeat (4) @(posedge clock);
    #1;
  endtask

  // Start, also used as repeated start
  task automatic startCond();
    sdaLow = 1'b0;
    phase();
    sclLine = 1'b1;
    phase();
    sdaLow = 1'b1;
    phase();
    sclLine = 1'b0;
  endtask

  task automatic stopCond();
    sdaLow = 1'b1;
    phase();
    sclLine = 1'b1;
    phase();
    sdaLow = 1'b0;
    phase();
  endtask

  // One bit slot, sampled at the end of the high phase
  task automatic bitSlot(input logic low, output logic seen);
    sdaLow = low;
    phase();
    sclLine = 1'b1;
    phase();
    seen = sdaLine;
    sclLine = 1'b0;
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitSlot(~b[i], s);
    end
    bitSlot(1'b0, s);
    ack = ~s;
  endtask

  task automatic recvByte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitSlot(1'b0, s);
      b[i] = s;
    end
    bitSlot(~last, s);
  endtask

  // Pointer byte first, then one data byte
  task automatic regWrite(input logic [7:0] ra, input logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    startCond();
    sendByte({DEV_ADDR, 1'b0}, a0);
    sendByte(ra, a1);
    sendByte(d, a2);
    stopCond();
    ok = a0 & a1 & a2;
  endtask

  // Pointer write, repeated start, one byte read ended by a nack
  task automatic regRead(input logic [7:0] ra, output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    startCond();
    sendByte({DEV_ADDR, 1'b0}, a0);
    sendByte(ra, a1);
    startCond();
    sendByte({DEV_ADDR, 1'b1}, a2);
    recvByte(1'b1, d);
    stopCond();
    ok = a0 & a1 & a2;
  endtask
endmodule

/* File: verif/test_ttc_control_regs.sv */
// Self-checking bench for the touch control register bank
`timescale 1ns/1ns
module test_ttc_control_regs;
  import ttc_pkg::*;
  localparam int COMP_SIM = 1000;  // Shortened compensation length
  localparam int MODE_SIM = 400;   // Shortened mode entry length
  logic clock, rst_n, sclLine, sdaLow, sdaLine, sdaOut, sdaOe, autoLightOn, autoCompReq;
  logic [7:0] pinIsGpo, pinIsPwm, powerupState, onLevel, offLevel, irqFlags, gpoExp;
  logic [7:0][7:0] pinLevel;
  logic [7:0] lvl [8];
  logic [1:0] opMode;
  logic compRunning, pmemMode, interruptOutN, chipResetPulse;
  int fails, checkCount, resetCount;

  // Open-drain data line with pull-up
  assign sdaLine = ~(sdaLow | (sdaOe & ~sdaOut));

  ttc_control_regs #(.COMP_CYCLES(COMP_SIM), .MODE_CYCLES(MODE_SIM)) u_ttc_control_regs (
    .clock(clock), .rst_n(rst_n), .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .pinIsGpo(pinIsGpo), .pinIsPwm(pinIsPwm), .autoLightOn(autoLightOn),
    .powerupState(powerupState), .onLevel(onLevel), .offLevel(offLevel),
    .autoCompReq(autoCompReq), .pinLevel(pinLevel), .opMode(opMode),
    .compRunning(compRunning), .pmemMode(pmemMode), .irqFlags(irqFlags),
    .interruptOutN(interruptOutN), .chipResetPulse(chipResetPulse));
  ttc_i2c_host u_ttc_i2c_host (.clock(clock), .sdaLine(sdaLine), .sclLine(sclLine),
    .sdaLow(sdaLow));

  // Clock and soft reset pulse counter
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (chipResetPulse === 1'b1) resetCount <= resetCount + 1;

  task automatic tally_and_finish();
    if (fails == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checkCount++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitFor(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic ok;
    u_ttc_i2c_host.regWrite(ra, d, ok);
    check("write ack", 8'h01, {7'h00, ok});
  endtask
  task automatic rd(input logic [7:0] ra, output logic [7:0] d);
    logic ok;
    u_ttc_i2c_host.regRead(ra, d, ok);
    check("read ack", 8'h01, {7'h00, ok});
  endtask
  task automatic waitIrq();
    int n;
    n = 0;
    while (interruptOutN !== 1'b0 && n < 2000) begin
      waitFor(1);
      n++;
    end
    check("interrupt", 8'h00, {7'h00, interruptOutN});
  endtask
  // Expected drive of every pin from the stored levels and control bits
  task automatic checkPins();
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      if (pinIsPwm[i]) e = lvl[i];
      else if (pinIsGpo[i] && !autoLightOn) e = gpoExp[i] ? onLevel : offLevel;
      else e = 8'h00;
      check("pin level", e, pinLevel[i]);
    end
  endtask
  task automatic resetImage();
    for (int i = 0; i < 8; i++) lvl[i] = powerupState[i] ? onLevel : offLevel;
    gpoExp = powerupState;
  endtask

  task automatic testResetImage();
    logic [7:0] d;
    logic ok;
    logic [7:0] ofs [6];
    logic [7:0] msk [6];
    logic [7:0] exp [6];
    ofs = '{OFS_MODE, OFS_GPO, OFS_PIN_SEL, OFS_GW_CFG, OFS_GW_BASE, 8'h0f};
    msk = '{8'h07, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
    exp = '{8'h00, powerupState, 8'h00, 8'h00, BASE_RESET, 8'h00};
    checkPins();
    for (int i = 0; i < 6; i++) begin
      rd(ofs[i], d);
      check("reset value", exp[i], d & msk[i]);
    end
    u_ttc_i2c_host.startCond();
    u_ttc_i2c_host.sendByte(8'h58, ok);
    u_ttc_i2c_host.stopCond();
    check("foreign address ack", 8'h00, {7'h00, ok});
  endtask

  task automatic testPwmLevels();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      lvl[i] = (i == 0) ? 8'hff : (i == 7) ? 8'h00 : 8'(17 * i);
      wr(OFS_PIN_SEL, 8'(i));
      wr(OFS_PIN_LEVEL, lvl[i]);
    end
    checkPins();
    for (int i = 7; i >= 0; i--) begin
      wr(OFS_PIN_SEL, 8'(i));
      rd(OFS_PIN_LEVEL, d);
      check("level readback", lvl[i], d);
    end
  endtask

  task automatic testGpo();
    logic [7:0] d;
    wr(OFS_GPO, 8'h5a);
    gpoExp = 8'h5a;
    rd(OFS_GPO, d);
    check("gpo masked", (8'h5a & pinIsGpo) | (powerupState & ~pinIsGpo), d);
    checkPins();
    autoLightOn = 1'b1;
    waitFor(3);
    checkPins();
    autoLightOn = 1'b0;
    waitFor(3);
    checkPins();
  endtask

  task automatic testModes();
    logic [7:0] d;
    wr(OFS_MODE, {6'h00, MODE_DOZE});
    check("mode pending", {6'h00, MODE_ACTIVE}, {6'h00, opMode});
    waitIrq();
    check("doze entered", {6'h00, MODE_DOZE}, {6'h00, opMode});
    check("mode flag", 8'h01, irqFlags & 8'h01);
    rd(OFS_MODE, d);
    check("mode read", {6'h00, MODE_DOZE}, d & 8'h07);
    check("flags cleared", 8'h01, {7'h00, interruptOutN});
    wr(OFS_MODE, {6'h00, MODE_RSVD});
    waitFor(MODE_SIM + 20);
    check("reserved mode", {6'h00, MODE_DOZE}, {6'h00, opMode});
    wr(OFS_MODE, {6'h00, MODE_SLEEP});
    check("sleep entered", {6'h00, MODE_SLEEP}, {6'h00, opMode});
    check("no flag on sleep", 8'h00, irqFlags);
  endtask

  task automatic testComp();
    logic [7:0] d;
    wr(OFS_MODE, 8'h06);
    check("comp running", 8'h01, {7'h00, compRunning});
    rd(OFS_MODE, d);
    check("comp bit set", 8'h06, d & 8'h07);
    waitIrq();
    check("comp flag", 8'h02, irqFlags & 8'h02);
    rd(OFS_MODE, d);
    check("comp bit clear", 8'h02, d & 8'h07);
    autoCompReq = 1'b1;
    waitFor(2);
    autoCompReq = 1'b0;
    check("auto comp running", 8'h01, {7'h00, compRunning});
    waitIrq();
    check("auto comp flag", 8'h02, irqFlags & 8'h02);
    // Read clears the compensation flag so the mode flag can pull the interrupt alone
    rd(OFS_GW_BASE, d);
    check("base untouched", BASE_RESET, d);
    wr(OFS_MODE, {6'h00, MODE_ACTIVE});
    waitIrq();
    check("active entered", 8'h01, irqFlags & 8'h01);
  endtask

  task automatic testPmem();
    logic [7:0] d;
    wr(OFS_GW_BASE, BASE_MASK);
    rd(OFS_GW_BASE, d);
    check("window base", BASE_MASK, d);
    wr(OFS_GW_CFG, 8'h10);
    check("memory mode", 8'h01, {7'h00, pmemMode});
    for (int i = 0; i < 8; i++) begin
      if (i == 7) check("early write flag", 8'h00, irqFlags & 8'h20);
      wr(8'(i), 8'(8'ha0 + i));
    end
    check("write flag", 8'h20, irqFlags & 8'h20);
    check("write irq", 8'h00, {7'h00, interruptOutN});
    wr(OFS_GW_CFG, 8'h18);
    for (int i = 0; i < 8; i++) begin
      rd(8'(i), d);
      check("window byte", 8'(8'ha0 + i), d);
    end
    wr(OFS_GW_CFG, 8'h00);
    check("normal mode", 8'h00, {7'h00, pmemMode});
    rd(OFS_GW_CFG, d);
    check("gateway cleared", 8'h00, d);
  endtask

  task automatic testSoftReset();
    logic [7:0] d;
    logic ok;
    int n0;
    n0 = resetCount;
    wr(OFS_PIN_SEL, 8'h05);
    wr(OFS_CHIP_RST, RST_KEY_FIRST);
    wr(OFS_CHIP_RST, 8'h55);
    wr(OFS_CHIP_RST, RST_KEY_LAST);
    check("broken key", 8'(n0), 8'(resetCount));
    rd(OFS_PIN_SEL, d);
    check("select kept", 8'h05, d);
    wr(OFS_CHIP_RST, RST_KEY_FIRST);
    u_ttc_i2c_host.regWrite(OFS_CHIP_RST, RST_KEY_LAST, ok);
    check("reset pulse", 8'(n0 + 1), 8'(resetCount));
    resetImage();
    checkPins();
    rd(OFS_PIN_SEL, d);
    check("select reset", 8'h00, d);
    rd(OFS_GPO, d);
    check("gpo reset", powerupState, d);
  endtask

  // Watchdog against a hung bus or handshake
  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    tally_and_finish();
  end

  initial begin
    rst_n = 1'b0;
    autoLightOn = 1'b0;
    autoCompReq = 1'b0;
    pinIsPwm = 8'h0f;
    pinIsGpo = 8'h78;
    powerupState = 8'ha5;
    onLevel = 8'hc3;
    offLevel = 8'h3c;
    fails = 0;
    checkCount = 0;
    resetCount = 0;
    resetImage();
    waitFor(16);
    rst_n = 1'b1;
    waitFor(2);
    testResetImage();
    testPwmLevels();
    testGpo();
    testModes();
    testComp();
    testPmem();
    testSoftReset();
    tally_and_finish();
  end
endmodule
